/* File: boot_loader_pkg.sv */
// Constants, encodings and helpers shared by the configuration loader files.
// Assumes a 25 MHz system clock driving the loader and its serial engine.
`default_nettype none

package boot_loader_pkg;

  localparam int          BYTE_W          = 8;
  localparam int          CLK_FREQ_HZ     = 25000000;
  localparam int          SCL_FREQ_HZ     = 64000;
  // A quarter of the serial clock period, rounded up so the rate never exceeds 64 kHz.
  localparam int          SCL_QUARTER_CYC = (CLK_FREQ_HZ + 4 * SCL_FREQ_HZ - 1) / (4 * SCL_FREQ_HZ);
  localparam logic [6:0]  QTR_LAST        = 7'(SCL_QUARTER_CYC - 1);
  localparam logic [6:0]  EEPROM_DEV_LOW  = 7'b1010000;
  localparam logic [6:0]  EEPROM_DEV_HIGH = 7'b1010001;
  localparam logic        RW_WRITE        = 1'b0;
  localparam logic        RW_READ         = 1'b1;
  localparam logic [3:0]  ACK_BIT         = 4'h8;
  localparam logic [7:0]  FIRST_WORD_ADDR = 8'h00;
  localparam logic [7:0]  LAST_WORD_ADDR  = 8'hff;
  localparam logic [7:0]  CMPL_EVEN       = 8'hff;
  localparam logic [7:0]  CMPL_ODD        = 8'h00;
  localparam logic [7:0]  COUNT_MARKER    = 8'hfe;
  localparam logic [7:0]  TX_MODE_REG     = 8'h00;
  localparam int          DRIVE_MODE_BIT  = 1;
  localparam logic [1:0]  SETTLE_LAST     = 2'h3;

  typedef enum logic [1:0] {STEP_DEV_WR, STEP_WORD, STEP_DEV_RD, STEP_DATA} i2c_step_e;

  function automatic logic [6:0] dev_addr(input logic sel);
    dev_addr = sel ? EEPROM_DEV_HIGH : EEPROM_DEV_LOW;
  endfunction

  function automatic logic is_cmpl(input logic [7:0] even_b, input logic [7:0] odd_b);
    is_cmpl = (even_b == CMPL_EVEN) && (odd_b == CMPL_ODD);
  endfunction

endpackage

`default_nettype wire

/* File: loader_i2c_if.sv */
// Request and answer bundle between the loader sequencer and its serial engine.
// Assumes both ends run on the same system clock.
`default_nettype none

interface loader_i2c_if;
  logic       req;
  logic [7:0] word_addr;
  logic       dev_sel;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rdata;

  modport ctrl (output req, word_addr, dev_sel, input busy, done, nack, rdata);
  modport eng  (input req, word_addr, dev_sel, output busy, done, nack, rdata);
endinterface

`default_nettype wire

/* File: eeprom_read_engine.sv */
// Two-wire master that performs one random read of one byte per request.
// Assumes word_addr and dev_sel stay stable from request until done.
`default_nettype none

module eeprom_read_engine (
  input  wire logic   mclk_in,
  input  wire logic   rst_b_in,
  loader_i2c_if.eng   ctl,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        scl_oe_out,
  output logic        sda_oe_out
);
  import boot_loader_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} eng_state_e;

  eng_state_e st_q, st_d;
  i2c_step_e  step_q, step_d;
  logic [1:0] q_q, q_d;
  logic [6:0] tick_q, tick_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rdata_q, rdata_d;
  logic       done_q, done_d;
  logic       nack_q, nack_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic       stretch, adv, bit_end;
  logic [7:0] low_cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stretch  = (st_q == E_BIT) && q_q[1] && !scl_oe_q && !scl_s_q;
    adv      = (tick_q == QTR_LAST) && !stretch;
    bit_end  = adv && (q_q == 2'h3);
    st_d     = st_q;
    step_d   = step_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    rdata_d  = rdata_q;
    nack_d   = nack_q;
    done_d   = 1'b0;
    tick_d   = (st_q == E_IDLE || adv) ? 7'h00 : (stretch ? tick_q : tick_q + 7'h01); // [RL5]
    q_d      = (st_q == E_IDLE) ? 2'h0 : (adv ? q_q + 2'h1 : q_q);
    case (st_q)
      E_IDLE: begin
        if (ctl.req) begin
          st_d   = E_START;
          step_d = STEP_DEV_WR;
          sh_d   = {dev_addr(ctl.dev_sel), RW_WRITE}; // [RL6]
          bit_d  = 4'h0;
          nack_d = 1'b0;
        end
      end
      E_START: begin
        if (bit_end) begin
          st_d  = E_BIT;
          bit_d = 4'h0;
        end
      end
      E_BIT: begin
        if (bit_end) begin
          if (bit_q != ACK_BIT) begin
            bit_d = bit_q + 4'h1;
            sh_d  = {sh_q[6:0], (step_q == STEP_DATA) ? sda_s_q : 1'b0};
          end else begin
            bit_d = 4'h0;
            if (step_q == STEP_DATA) begin
              rdata_d = sh_q;
              st_d    = E_STOP;
            end else if (sda_s_q) begin
              nack_d = 1'b1; // [RL20]
              st_d   = E_STOP;
            end else if (step_q == STEP_DEV_WR) begin
              step_d = STEP_WORD;
              sh_d   = ctl.word_addr;
            end else if (step_q == STEP_WORD) begin
              // The word address write is only a pointer set; a repeated start follows.
              step_d = STEP_DEV_RD; // [RL3] [RL4]
              sh_d   = {dev_addr(ctl.dev_sel), RW_READ}; // [RL6]
              st_d   = E_START;
            end else begin
              step_d = STEP_DATA;
              sh_d   = 8'h00;
            end
          end
        end
      end
      E_STOP: begin
        if (bit_end) begin
          st_d   = E_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = E_IDLE;
    endcase
    // Data bits change only in the second quarter, well inside the clock low phase; start and stop edges move data while the clock is high.
    scl_oe_d = 1'b0;
    sda_oe_d = sda_oe_q;
    case (st_q)
      E_START: begin
        scl_oe_d = (q_q == 2'h0);
        sda_oe_d = q_q[1];
      end
      E_BIT: begin
        scl_oe_d = !q_q[1];
        if (q_q == 2'h1) begin
          sda_oe_d = (step_q != STEP_DATA) && (bit_q != ACK_BIT) && !sh_q[7];
        end
      end
      E_STOP: begin
        scl_oe_d = !q_q[1];
        if (q_q == 2'h1) begin
          sda_oe_d = 1'b1;
        end else if (q_q == 2'h3) begin
          sda_oe_d = 1'b0;
        end
      end
      default: sda_oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q     <= E_IDLE;
      step_q   <= STEP_DEV_WR;
      q_q      <= 2'h0;
      tick_q   <= 7'h00;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      rdata_q  <= 8'h00;
      done_q   <= 1'b0;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_m_q  <= 1'b1;
      scl_s_q  <= 1'b1;
      sda_m_q  <= 1'b1;
      sda_s_q  <= 1'b1;
    end else begin
      st_q     <= st_d;
      step_q   <= step_d;
      q_q      <= q_d;
      tick_q   <= tick_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      rdata_q  <= rdata_d;
      done_q   <= done_d;
      nack_q   <= nack_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      scl_m_q  <= scl_in;
      scl_s_q  <= scl_m_q;
      sda_m_q  <= sda_in;
      sda_s_q  <= sda_m_q;
    end
  end

  assign ctl.busy   = (st_q != E_IDLE);
  assign ctl.done   = done_q;
  assign ctl.nack   = nack_q;
  assign ctl.rdata  = rdata_q;
  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt_q <= 8'h00;
    end else begin
      low_cnt_q <= scl_oe_q ? low_cnt_q + 8'h01 : 8'h00;
    end
  end

  a_scl_low_time: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL5]
    $fell(scl_oe_q) |-> (low_cnt_q == 8'(SCL_QUARTER_CYC) || low_cnt_q == 8'(2 * SCL_QUARTER_CYC)))
    else $error("serial clock low time is not one or two quarter periods");

  a_dev_addr_byte: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL6]
    (st_q == E_BIT && bit_q == 4'h0 && (step_q == STEP_DEV_WR || step_q == STEP_DEV_RD))
    |-> (sh_q[7:1] == dev_addr(ctl.dev_sel) && sh_q[0] == (step_q == STEP_DEV_RD)))
    else $error("device address byte does not match the select pin");

  a_word_restart: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL3] [RL4]
    (st_q == E_BIT && step_q == STEP_WORD && bit_q == ACK_BIT && bit_end)
    |=> (st_q == E_START && step_q == STEP_DEV_RD) || st_q == E_STOP)
    else $error("word address write not followed by repeated start");

endmodule

`default_nettype wire

/* File: boot_config_loader.sv */
// Start-up loader: reads address/data pairs from a serial EEPROM, writes local
// registers, optionally waits on return-link packets and forwards receiver pairs.
// Assumes the wireless link logic runs on its own clock and sees one pair at a time.
//
// Behaviour
// RL1 - Load EEPROM pairs into local registers at start-up.
// RL2 - Fetch from word zero, step address by one.
// RL3 - Each byte uses a random read transaction.
// RL4 - Never write EEPROM contents.
// RL5 - Serial clock fixed at 64 kHz.
// RL6 - Device address follows the select pin.
// RL7 - Eight-bit word address, 0 through 255.
// RL8 - Even byte is address, odd byte data.
// RL9 - FF then 00 ends transmitter setting area.
// RL10 - Image writes 04 to header register 48.
// RL11 - Mode register bit one enters drive mode.
// RL12 - Marker FE then count of return packets.
// RL13 - Pause until count plus one packets arrive.
// RL14 - Image holds marker only when needed.
// RL15 - Forward receiver pairs over forward link.
// RL16 - Forwarding only in automatic transfer mode.
// RL17 - Image may end receiver area at once.
// RL18 - Image ends with charge enable pair.
// RL19 - Second completion code stops all fetching.
// RL20 - No acknowledge or overrun flags an error.
`default_nettype none

module boot_config_loader (
  input  wire logic                               mclk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               eeprom_sel_in,
  input  wire logic                               auto_mode_in,
  input  wire logic                               scl_in,
  output logic                                    scl_out,
  output logic                                    scl_oe_out,
  input  wire logic                               sda_in,
  output logic                                    sda_out,
  output logic                                    sda_oe_out,
  output logic                                    reg_wr_out,
  output logic [boot_loader_pkg::BYTE_W-1:0]      reg_addr_out,
  output logic [boot_loader_pkg::BYTE_W-1:0]      reg_data_out,
  output logic                                    drive_mode_out,
  output logic                                    loading_out,
  output logic                                    done_out,
  output logic                                    error_out,
  input  wire logic                               wlink_clk_in,
  input  wire logic                               ret_pkt_in,
  output logic                                    fwd_valid_out,
  input  wire logic                               fwd_ready_in,
  output logic [boot_loader_pkg::BYTE_W-1:0]      fwd_addr_out,
  output logic [boot_loader_pkg::BYTE_W-1:0]      fwd_data_out
);
  import boot_loader_pkg::*;

  typedef enum logic [2:0] {S_STRAP, S_REQ, S_WAIT, S_COUNT, S_FWD, S_DONE, S_ERR} ld_state_e;
  typedef enum logic [1:0] {A_TX, A_POST, A_RX} area_e;

  loader_i2c_if ctl ();

  ld_state_e  st_q, st_d;
  area_e      area_q, area_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] hold_q, hold_d;
  logic       sel_q, sel_d;
  logic [1:0] settle_q, settle_d;
  logic [8:0] cnt_q, cnt_d;
  logic [8:0] pkt_q, pkt_d;
  logic       reg_wr_q, reg_wr_d;
  logic [7:0] reg_addr_q, reg_addr_d;
  logic [7:0] reg_data_q, reg_data_d;
  logic       drive_q, drive_d;
  logic [7:0] fwd_addr_q, fwd_addr_d;
  logic [7:0] fwd_data_q, fwd_data_d;
  logic       fwd_tgl_q, fwd_tgl_d;
  logic       err_q, err_d;

  logic       sel_m_q, sel_s_q;
  logic       auto_m_q, auto_s_q;
  logic       ack_m_q, ack_s_q;
  logic       pkt_m_q, pkt_s_q, pkt_p_q;
  logic       pkt_evt;

  logic       pair_cmpl, tx_write, tx_end, post_marker, rx_pair;

  logic       lk_valid_q, lk_valid_d;
  logic [7:0] lk_addr_q, lk_addr_d;
  logic [7:0] lk_data_q, lk_data_d;
  logic       lk_ack_tgl_q, lk_ack_tgl_d;
  logic       lk_pkt_tgl_q, lk_pkt_tgl_d;
  logic       lk_req_m_q, lk_req_s_q, lk_req_p_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial engine.

  eeprom_read_engine u_engine (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .ctl        (ctl.eng),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_oe_out (scl_oe_out),
    .sda_oe_out (sda_oe_out)
  );

  assign ctl.req       = (st_q == S_REQ);
  assign ctl.word_addr = addr_q; // [RL7]
  assign ctl.dev_sel   = sel_q; // [RL6]

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer on the system clock.

  assign pkt_evt   = pkt_s_q ^ pkt_p_q;
  assign pair_cmpl = is_cmpl(hold_q, ctl.rdata);

  always_comb begin
    st_d        = st_q;
    area_d      = area_q;
    addr_d      = addr_q;
    hold_d      = hold_q;
    sel_d       = sel_q;
    settle_d    = settle_q;
    cnt_d       = cnt_q;
    pkt_d       = pkt_q;
    reg_wr_d    = 1'b0;
    reg_addr_d  = reg_addr_q;
    reg_data_d  = reg_data_q;
    drive_d     = drive_q;
    fwd_addr_d  = fwd_addr_q;
    fwd_data_d  = fwd_data_q;
    fwd_tgl_d   = fwd_tgl_q;
    err_d       = err_q;
    tx_write    = 1'b0;
    tx_end      = 1'b0;
    post_marker = 1'b0;
    rx_pair     = 1'b0;
    case (st_q)
      S_STRAP: begin
        // The select strap is caught once, after its synchroniser has settled.
        settle_d = settle_q + 2'h1;
        if (settle_q == SETTLE_LAST) begin
          sel_d  = sel_s_q;
          addr_d = FIRST_WORD_ADDR; // [RL2]
          st_d   = S_REQ;
        end
      end
      S_REQ: st_d = S_WAIT;
      S_WAIT: begin
        if (ctl.done) begin
          st_d = S_REQ;
          if (ctl.nack) begin
            err_d = 1'b1; // [RL20]
            st_d  = S_ERR;
          end else if (!addr_q[0]) begin
            hold_d = ctl.rdata; // [RL8]
          end else begin
            case (area_q)
              A_TX: begin
                if (pair_cmpl) begin
                  tx_end = 1'b1; // [RL9]
                end else begin
                  tx_write = 1'b1; // [RL1] [RL8]
                end
              end
              A_POST: begin
                area_d = A_RX;
                if (hold_q == COUNT_MARKER) begin
                  post_marker = 1'b1; // [RL12]
                  cnt_d       = {1'b0, ctl.rdata} + 9'h001; // [RL13]
                  pkt_d       = 9'h000;
                  st_d        = S_COUNT;
                end else begin
                  rx_pair = 1'b1;
                end
              end
              default: rx_pair = 1'b1;
            endcase
            if (rx_pair) begin
              if (pair_cmpl) begin
                st_d = S_DONE; // [RL19]
              end else if (auto_s_q) begin
                fwd_addr_d = hold_q; // [RL15] [RL16]
                fwd_data_d = ctl.rdata;
                fwd_tgl_d  = !fwd_tgl_q;
                st_d       = S_FWD;
              end
            end
          end
          if (st_d != S_DONE && st_d != S_ERR) begin
            if (addr_q == LAST_WORD_ADDR) begin
              err_d = 1'b1; // [RL20] [RL7]
              st_d  = S_ERR;
            end else begin
              addr_d = addr_q + 8'h01; // [RL2]
            end
          end
        end
      end
      S_COUNT: begin
        if (pkt_evt) begin
          pkt_d = pkt_q + 9'h001;
          if (pkt_q + 9'h001 == cnt_q) begin
            st_d = S_REQ; // [RL13]
          end
        end
      end
      S_FWD: begin
        if (ack_s_q == fwd_tgl_q) begin
          st_d = S_REQ; // [RL15]
        end
      end
      S_DONE: st_d = S_DONE;
      S_ERR:  st_d = S_ERR;
      default: st_d = S_ERR;
    endcase
    if (tx_end) begin
      area_d = A_POST; // [RL9]
    end
    if (tx_write) begin
      reg_wr_d   = 1'b1; // [RL1]
      reg_addr_d = hold_q;
      reg_data_d = ctl.rdata;
      if (hold_q == TX_MODE_REG && ctl.rdata[DRIVE_MODE_BIT]) begin
        drive_d = 1'b1; // [RL11]
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q       <= S_STRAP;
      area_q     <= A_TX;
      addr_q     <= FIRST_WORD_ADDR;
      hold_q     <= 8'h00;
      sel_q      <= 1'b0;
      settle_q   <= 2'h0;
      cnt_q      <= 9'h000;
      pkt_q      <= 9'h000;
      reg_wr_q   <= 1'b0;
      reg_addr_q <= 8'h00;
      reg_data_q <= 8'h00;
      drive_q    <= 1'b0;
      fwd_addr_q <= 8'h00;
      fwd_data_q <= 8'h00;
      fwd_tgl_q  <= 1'b0;
      err_q      <= 1'b0;
      sel_m_q    <= 1'b0;
      sel_s_q    <= 1'b0;
      auto_m_q   <= 1'b0;
      auto_s_q   <= 1'b0;
      ack_m_q    <= 1'b0;
      ack_s_q    <= 1'b0;
      pkt_m_q    <= 1'b0;
      pkt_s_q    <= 1'b0;
      pkt_p_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      area_q     <= area_d;
      addr_q     <= addr_d;
      hold_q     <= hold_d;
      sel_q      <= sel_d;
      settle_q   <= settle_d;
      cnt_q      <= cnt_d;
      pkt_q      <= pkt_d;
      reg_wr_q   <= reg_wr_d;
      reg_addr_q <= reg_addr_d;
      reg_data_q <= reg_data_d;
      drive_q    <= drive_d;
      fwd_addr_q <= fwd_addr_d;
      fwd_data_q <= fwd_data_d;
      fwd_tgl_q  <= fwd_tgl_d;
      err_q      <= err_d;
      sel_m_q    <= eeprom_sel_in;
      sel_s_q    <= sel_m_q;
      auto_m_q   <= auto_mode_in;
      auto_s_q   <= auto_m_q;
      ack_m_q    <= lk_ack_tgl_q;
      ack_s_q    <= ack_m_q;
      pkt_m_q    <= lk_pkt_tgl_q;
      pkt_s_q    <= pkt_m_q;
      pkt_p_q    <= pkt_s_q;
    end
  end

  assign scl_out        = 1'b0;
  assign sda_out        = 1'b0;
  assign reg_wr_out     = reg_wr_q;
  assign reg_addr_out   = reg_addr_q;
  assign reg_data_out   = reg_data_q;
  assign drive_mode_out = drive_q;
  assign loading_out    = (st_q != S_DONE) && (st_q != S_ERR);
  assign done_out       = (st_q == S_DONE);
  assign error_out      = err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Link side on the wireless link clock.

  always_comb begin
    lk_valid_d   = lk_valid_q;
    lk_addr_d    = lk_addr_q;
    lk_data_d    = lk_data_q;
    lk_ack_tgl_d = lk_ack_tgl_q;
    lk_pkt_tgl_d = lk_pkt_tgl_q ^ ret_pkt_in;
    // The pair registers are held still by the sequencer while a request is pending.
    if (lk_req_s_q != lk_req_p_q) begin
      lk_valid_d = 1'b1; // [RL15]
      lk_addr_d  = fwd_addr_q;
      lk_data_d  = fwd_data_q;
    end else if (lk_valid_q && fwd_ready_in) begin
      lk_valid_d   = 1'b0;
      lk_ack_tgl_d = !lk_ack_tgl_q;
    end
  end

  always_ff @(posedge wlink_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk_valid_q   <= 1'b0;
      lk_addr_q    <= 8'h00;
      lk_data_q    <= 8'h00;
      lk_ack_tgl_q <= 1'b0;
      lk_pkt_tgl_q <= 1'b0;
      lk_req_m_q   <= 1'b0;
      lk_req_s_q   <= 1'b0;
      lk_req_p_q   <= 1'b0;
    end else begin
      lk_valid_q   <= lk_valid_d;
      lk_addr_q    <= lk_addr_d;
      lk_data_q    <= lk_data_d;
      lk_ack_tgl_q <= lk_ack_tgl_d;
      lk_pkt_tgl_q <= lk_pkt_tgl_d;
      lk_req_m_q   <= fwd_tgl_q;
      lk_req_s_q   <= lk_req_m_q;
      lk_req_p_q   <= lk_req_s_q;
    end
  end

  assign fwd_valid_out = lk_valid_q;
  assign fwd_addr_out  = lk_addr_q;
  assign fwd_data_out  = lk_data_q;

  ////////////////////////////////////////////////////////////////////////////////
  a_addr_step: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL2]
    (st_q != S_STRAP && addr_q != $past(addr_q)) |-> addr_q == $past(addr_q) + 8'h01)
    else $error("word address did not advance by one");

  a_no_wrap: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL7] [RL20]
    (addr_q == LAST_WORD_ADDR && st_q == S_WAIT && ctl.done && !pair_cmpl)
    |=> (st_q == S_ERR && err_q && addr_q == LAST_WORD_ADDR))
    else $error("word address wrapped instead of flagging an error");

  a_local_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL1] [RL8]
    tx_write |=> reg_wr_q && reg_addr_q == $past(hold_q) && reg_data_q == $past(ctl.rdata))
    else $error("local register write does not carry the fetched pair");

  a_tx_end: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL9]
    (st_q == S_WAIT && ctl.done && !ctl.nack && addr_q[0] && area_q == A_TX && pair_cmpl)
    |=> area_q == A_POST && !reg_wr_q)
    else $error("completion code did not close the transmitter area");

  a_drive_mode: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL11]
    (reg_wr_q && reg_addr_q == TX_MODE_REG && reg_data_q[DRIVE_MODE_BIT]) |-> drive_q)
    else $error("mode register write did not enter drive mode");

  a_count_marker: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL12]
    post_marker |=> st_q == S_COUNT && cnt_q == {1'b0, $past(ctl.rdata)} + 9'h001)
    else $error("count marker not taken as packet count");

  a_count_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL13]
    (st_q == S_COUNT && !(pkt_evt && pkt_q + 9'h001 == cnt_q)) |=> st_q == S_COUNT && !ctl.req)
    else $error("reading resumed before count plus one packets");

  a_fwd_auto: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL16]
    (fwd_tgl_q != $past(fwd_tgl_q)) |-> $past(auto_s_q))
    else $error("pair forwarded outside automatic transfer mode");

  a_done_stops: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RL19]
    (st_q == S_DONE) |=> st_q == S_DONE && !ctl.req && !ctl.busy)
    else $error("fetching continued after the final completion code");

  a_fwd_hold: assert property (@(posedge wlink_clk_in) disable iff (!rst_b_in) // [RL15]
    (lk_valid_q && !fwd_ready_in) |=> lk_valid_q && $stable(lk_addr_q) && $stable(lk_data_q))
    else $error("forward pair dropped before the link accepted it");

endmodule

`default_nettype wire

/* File: cfg_eeprom_model.sv */
// Behavioural two-wire EEPROM that answers random reads from a small image.
// Assumes the bench resolves both open-drain wires with pull-ups.
`default_nettype none
module cfg_eeprom_model #(parameter logic [6:0] DEV = 7'b1010001) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var logic  pull_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  int         n = 0;
  int         k = 0;
  logic       rd = 0;
  logic       sel = 0;
  initial begin
    pull_out = 0;
    foreach (mem[i]) mem[i] = 8'hff;
    mem[0] = 8'h00;
    mem[1] = 8'h02;
    mem[3] = 8'h00;
    mem[5] = 8'h00;
    // No receiver pairs follow, so the header write and charge pair are absent.
  end
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    n = 0;
    k = 0;
  end
  always @(posedge scl_in) begin
    sh = {sh[6:0], sda_in};
    n = n + 1;
  end
  // Acknowledges address bytes, then shifts the addressed byte out.
  always @(negedge scl_in) begin
    pull_out = 0;
    if (n == 9) n = 0;
    else if (n == 8 && rd && k == 1) k = 2;
    else if (n == 8) begin
      if (k == 0) begin
        sel = (sh[7:1] == DEV);
        rd = sh[0];
      end else if (sel) ptr = sh;
      pull_out = sel;
      k = k + 1;
    end
    if (rd && sel && k == 1 && n < 8) pull_out = ~mem[ptr][7 - n];
  end
endmodule
`default_nettype wire

/* File: boot_config_loader_bench.sv */
// Self-checking bench for the start-up loader against a two-wire EEPROM model.
// Assumes the model image: one drive-mode write, then two completion codes.
`default_nettype none
module boot_config_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 0;
  logic        wlink_clk_in = 0;
  logic        rst_b_in = 0;
  logic        eeprom_sel_in = 0;
  logic        scl_oe, sda_oe, pull, reg_wr, drive, loading, done, error, fwd_valid;
  logic        scl_o, sda_o;
  logic [7:0]  reg_addr, reg_data, fwd_addr, fwd_data;
  wire logic   scl = ~scl_oe;
  wire logic   sda = ~(sda_oe | pull);
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [15:0] rows [1] = '{16'h0002};
  always #20 mclk_in = ~mclk_in;
  always #6 wlink_clk_in = ~wlink_clk_in;
  boot_config_loader boot_config_loader_inst (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .eeprom_sel_in(eeprom_sel_in),
    .auto_mode_in(1'b1), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .reg_wr_out(reg_wr),
    .reg_addr_out(reg_addr), .reg_data_out(reg_data), .drive_mode_out(drive),
    .loading_out(loading), .done_out(done), .error_out(error),
    .wlink_clk_in(wlink_clk_in), .ret_pkt_in(1'b0), .fwd_valid_out(fwd_valid),
    .fwd_ready_in(1'b1), .fwd_addr_out(fwd_addr), .fwd_data_out(fwd_data));
  cfg_eeprom_model cfg_eeprom_model_inst (.scl_in(scl), .sda_in(sda), .pull_out(pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_high(ref logic sig, input int limit);
    for (int i = 0; i < limit && sig !== 1'b1; i++) @(posedge mclk_in) #1;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 99000) begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk_in);
    #1 rst_b_in = 1;
    // Strap low addresses a device that is absent, so the loader must give up.
    wait_high(error, 10000);
    check(16'({error, loading, done, scl_oe, sda_oe}), 16'h10);
    rst_b_in = 0;
    eeprom_sel_in = 1;
    repeat (2) @(posedge mclk_in);
    #1 check(16'({error, done, drive, loading, reg_wr, fwd_valid}), 16'h4);
    check(16'({scl_oe, sda_oe, scl_o, sda_o}), 16'h0);
    check({fwd_addr, fwd_data}, 16'h0000);
    check({reg_addr, reg_data}, 16'h0000);
    rst_b_in = 1;
    foreach (rows[i]) begin
      wait_high(reg_wr, 40000);
      check({reg_addr, reg_data}, rows[i]);
      check(16'(drive), 16'h1);
      @(posedge mclk_in) #1;
    end
    // An empty receiver area ends loading with nothing forwarded.
    wait_high(done, 70000);
    check(16'({done, error, loading, drive, fwd_valid}), 16'h12);
    check(16'({scl_oe, sda_oe, scl_o, sda_o}), 16'h0);
    complete_run();
  end
endmodule
`default_nettype wire
